/* verilog/spa_params.svh */
// Constants for the serial port instruction and register addressing block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------
`define SPA_INSTR_RW_BIT 15
`define SPA_INSTR_LEN_HI 14
`define SPA_INSTR_LEN_LO 13
`define SPA_INSTR_ADDR_HI 12
`define SPA_LEN_STREAM 2'h3
`define SPA_BIT_LAST 3'h7
`define SPA_BIT_FIRST 3'h0
`define SPA_ADDR_STEP 13'h0001

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPA_ADDR_CFG 13'h0000
`define SPA_ADDR_A 13'h0004
`define SPA_ADDR_BH 13'h0005
`define SPA_ADDR_BL 13'h0006
`define SPA_ADDR_PLL1 13'h0007
`define SPA_ADDR_UPDATE 13'h005A

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SPA_CFG_BIDIR 7
`define SPA_CFG_LSB_FIRST 6
`define SPA_CFG_WMASK 8'hE0
`define SPA_UPDATE_BIT 0
`define SPA_RST_CFG 8'h10
`define SPA_RST_ZERO 8'h00

`endif

/* verilog/spa_pkg.sv */
// Types shared by the serial port instruction and addressing block.
// Assumes nothing of its surroundings.
`default_nettype none

package spa_pkg;
    // Phase of the serial communication cycle
    typedef enum logic [1:0] {
        SPA_INSTR,
        SPA_DATA,
        SPA_DONE
    } spa_state_t;
endpackage

`default_nettype wire

/* verilog/spa_serial_port.sv */
// Serial control port: instruction decode, address generator, shadow
// and active registers, and a two-entry write buffer.
// Assumes sclk, chip_select_n and sdio_in come from the pins, unsynced;
// shadow_hold comes from logic on sys_clk.
`default_nettype none
`include "spa_params.svh"

// What this block does
// R1 - Word is flag, length code, 13-bit address
// R2 - Length codes give 1, 2, 3 bytes, stream
// R3 - Host keeps upper six address bits zero
// R4 - MSB-first multibyte address decrements per byte
// R5 - LSB-first multibyte address increments per byte
// R6 - MSB-first default; config bit 6 selects LSB
// R7 - Bit order change acts at once
// R8 - Host shifts MSB first, high to low
// R9 - Host shifts LSB first, low to high
// R10 - Address generator never skips unused addresses
// R11 - Writes go to shadow; update bit commits
// R12 - Flag one shifts out buffered register bytes
// R13 - Capture on rising, change on falling
// R14 - Mid-byte chip select rise discards transfer
// R15 - Commit byte after eight bits, then advance
module spa_serial_port #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdio_in,
    input wire logic shadow_hold,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic sdio_out,
    output logic sdio_oe,
    output logic buffer_ready,
    output logic write_dropped,
    output logic [DATA_W-1:0] port_config,
    output logic [DATA_W-1:0] feedback_a_count,
    output logic [DATA_W-1:0] feedback_b_count_high,
    output logic [DATA_W-1:0] feedback_b_count_low,
    output logic [DATA_W-1:0] loop_control_one
);
    localparam int ENT_W = ADDR_W + DATA_W;
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sclk_s; // Stage 0 feeds stage 1 only
    logic [2:0] cs_s; // Stage 2 holds the previous level
    logic [1:0] sdio_s; // Same depth as sclk so data lines up
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            sdio_s <= 2'h0;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s <= {cs_s[1:0], chip_select_n};
            sdio_s <= {sdio_s[0], sdio_in};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];
    assign cs_rise = cs_s[1] & ~cs_s[2];

    // ----------------------------------------------------------------
    // Serial state
    // ----------------------------------------------------------------
    spa_pkg::spa_state_t state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt; // Bits of the current byte
    logic byte_cnt, next_byte_cnt; // Instruction byte index
    logic [15:0] instr, next_instr;
    logic [DATA_W-1:0] rx, next_rx;
    logic [DATA_W-1:0] tx, next_tx;
    logic rw, next_rw;
    logic [1:0] len, next_len;
    logic [1:0] left, next_left; // Bytes still due after this one
    logic [ADDR_W-1:0] addr, next_addr;
    logic next_dout, next_sdo_oe, next_sdio_oe;
    logic push, next_dropped;
    logic [ENT_W-1:0] push_ent;
    logic [DATA_W-1:0] shd_cfg, shd_a, shd_bh, shd_bl, shd_pll1;
    logic lsb;
    logic reading;

    // Bit order and pin direction follow the shadow config at once
    assign lsb = shd_cfg[`SPA_CFG_LSB_FIRST]; // R6 R7

    // Readback always comes from the shadow copy
    function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = `SPA_RST_ZERO;
        case (a)
            `SPA_ADDR_CFG: v = shd_cfg;
            `SPA_ADDR_A: v = shd_a;
            `SPA_ADDR_BH: v = shd_bh;
            `SPA_ADDR_BL: v = shd_bl;
            `SPA_ADDR_PLL1: v = shd_pll1;
            default: v = `SPA_RST_ZERO;
        endcase
        return v; // R12
    endfunction

    // Next values of the shifter, decoder and address generator
    always_comb begin
        logic b;
        logic [15:0] w;
        b = sdio_s[1];
        w = instr;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_instr = instr;
        next_rx = rx;
        next_tx = tx;
        next_rw = rw;
        next_len = len;
        next_left = left;
        next_addr = addr;
        next_dout = serial_data_out;
        push = 1'b0;
        push_ent = {addr, rx};
        reading = rw && (state != spa_pkg::SPA_INSTR);
        if (cs_s[1]) begin
            // Stall is kept only on a byte boundary of the instruction or of a bounded transfer's data
            if (cs_rise && (bit_cnt != `SPA_BIT_FIRST
                    || state == spa_pkg::SPA_DONE
                    || (state == spa_pkg::SPA_DATA
                        && len == `SPA_LEN_STREAM))) begin
                next_state = spa_pkg::SPA_INSTR; // R14
                next_bit_cnt = `SPA_BIT_FIRST; // R14
                next_byte_cnt = 1'b0;
            end
        end else if (sclk_rise) begin
            // Sample on the rising edge, in the order now in force
            if (state == spa_pkg::SPA_INSTR) begin
                next_instr = lsb ? {b, instr[15:1]}
                                 : {instr[14:0], b}; // R13 R8 R9
            end else begin
                next_rx = lsb ? {b, rx[DATA_W-1:1]}
                              : {rx[DATA_W-2:0], b}; // R13
            end
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `SPA_BIT_LAST) begin
                if (state == spa_pkg::SPA_INSTR) begin
                    next_byte_cnt = ~byte_cnt;
                    if (byte_cnt) begin
                        w = next_instr;
                        next_rw = w[`SPA_INSTR_RW_BIT]; // R1
                        next_len = w[`SPA_INSTR_LEN_HI:`SPA_INSTR_LEN_LO];
                        next_left = next_len; // R2
                        // All 13 bits compared; upper bits set hit nothing
                        next_addr = w[`SPA_INSTR_ADDR_HI:0]; // R1 R3
                        next_tx = rd(next_addr); // R12
                        next_state = spa_pkg::SPA_DATA;
                    end
                end else if (state == spa_pkg::SPA_DATA) begin
                    // Whole byte in: hand it on, then step the address
                    push = !rw; // R15 R11
                    push_ent = {addr, next_rx};
                    next_addr = lsb ? addr + `SPA_ADDR_STEP // R5 R10
                                    : addr - `SPA_ADDR_STEP; // R4 R10
                    next_tx = rd(next_addr);
                    if (len != `SPA_LEN_STREAM) begin
                        if (left == 2'h0) begin
                            next_state = spa_pkg::SPA_DONE; // R2
                        end else begin
                            next_left = left - 2'h1;
                        end
                    end
                end
            end
        end else if (sclk_fall && rw && state == spa_pkg::SPA_DATA) begin
            // Read bits change on the falling edge
            next_dout = lsb ? tx[0] : tx[DATA_W-1]; // R13 R12
            next_tx = lsb ? {1'b0, tx[DATA_W-1:1]}
                          : {tx[DATA_W-2:0], 1'b0};
        end
        // Pins float while chip select is high
        next_sdo_oe = !cs_s[1] && reading && !shd_cfg[`SPA_CFG_BIDIR];
        next_sdio_oe = !cs_s[1] && reading && shd_cfg[`SPA_CFG_BIDIR];
    end

    // Register the serial state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= spa_pkg::SPA_INSTR;
            bit_cnt <= `SPA_BIT_FIRST;
            byte_cnt <= 1'b0;
            instr <= 16'h0000;
            rx <= `SPA_RST_ZERO;
            tx <= `SPA_RST_ZERO;
            rw <= 1'b0;
            len <= 2'h0;
            left <= 2'h0;
            addr <= `SPA_ADDR_CFG;
            serial_data_out <= 1'b0;
            sdio_out <= 1'b0;
            serial_data_out_oe <= 1'b0;
            sdio_oe <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            instr <= next_instr;
            rx <= next_rx;
            tx <= next_tx;
            rw <= next_rw;
            len <= next_len;
            left <= next_left;
            addr <= next_addr;
            serial_data_out <= next_dout;
            sdio_out <= next_dout;
            serial_data_out_oe <= next_sdo_oe;
            sdio_oe <= next_sdio_oe;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer and register file
    // ----------------------------------------------------------------
    logic [ENT_W-1:0] fifo [DEPTH]; // Address and data per entry
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CNT_W-1:0] count, next_count;
    logic in_ready, pop, take;
    logic [ENT_W-1:0] head;
    logic [DATA_W-1:0] next_cfg, next_a, next_bh, next_bl, next_pll1;
    logic [DATA_W-1:0] next_act_a, next_act_bh, next_act_bl, next_act_pll1;

    // The serial side cannot pause, so a byte met by a full buffer is
    // dropped and flagged; a short hold never reaches that point
    assign in_ready = count != FULL;
    assign take = push && in_ready;
    assign pop = (count != '0) && !shadow_hold;
    assign head = fifo[rd_ptr];

    // Pointers, occupancy and shadow/active next values
    always_comb begin
        logic [ADDR_W-1:0] wa;
        logic [DATA_W-1:0] wd;
        wa = head[ENT_W-1:DATA_W];
        wd = head[DATA_W-1:0];
        next_wr_ptr = take ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
        next_count = CNT_W'(count + CNT_W'(take) - CNT_W'(pop));
        next_dropped = push && !in_ready;
        next_cfg = shd_cfg;
        next_a = shd_a;
        next_bh = shd_bh;
        next_bl = shd_bl;
        next_pll1 = shd_pll1;
        next_act_a = feedback_a_count;
        next_act_bh = feedback_b_count_high;
        next_act_bl = feedback_b_count_low;
        next_act_pll1 = loop_control_one;
        if (pop) begin
            case (wa)
                `SPA_ADDR_CFG: next_cfg = (wd & `SPA_CFG_WMASK)
                    | (shd_cfg & ~`SPA_CFG_WMASK);
                `SPA_ADDR_A: next_a = wd; // R11
                `SPA_ADDR_BH: next_bh = wd;
                `SPA_ADDR_BL: next_bl = wd;
                `SPA_ADDR_PLL1: next_pll1 = wd;
                `SPA_ADDR_UPDATE: begin
                    // Update bit is never stored, so it reads back zero
                    if (wd[`SPA_UPDATE_BIT]) begin
                        next_act_a = shd_a; // R11
                        next_act_bh = shd_bh;
                        next_act_bl = shd_bl;
                        next_act_pll1 = shd_pll1;
                    end
                end
                default: next_cfg = shd_cfg;
            endcase
        end
    end

    // Buffer storage, one entry written per accepted byte
    always_ff @(posedge sys_clk) begin
        if (take) begin
            fifo[wr_ptr] <= push_ent;
        end
    end

    // Register pointers, shadow and active copies
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            buffer_ready <= 1'b1;
            write_dropped <= 1'b0;
            shd_cfg <= `SPA_RST_CFG;
            shd_a <= `SPA_RST_ZERO;
            shd_bh <= `SPA_RST_ZERO;
            shd_bl <= `SPA_RST_ZERO;
            shd_pll1 <= `SPA_RST_ZERO;
            port_config <= `SPA_RST_CFG;
            feedback_a_count <= `SPA_RST_ZERO;
            feedback_b_count_high <= `SPA_RST_ZERO;
            feedback_b_count_low <= `SPA_RST_ZERO;
            loop_control_one <= `SPA_RST_ZERO;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            buffer_ready <= next_count != FULL;
            write_dropped <= next_dropped;
            shd_cfg <= next_cfg;
            shd_a <= next_a;
            shd_bh <= next_bh;
            shd_bl <= next_bl;
            shd_pll1 <= next_pll1;
            port_config <= next_cfg; // R7
            feedback_a_count <= next_act_a;
            feedback_b_count_high <= next_act_bh;
            feedback_b_count_low <= next_act_bl;
            loop_control_one <= next_act_pll1;
        end
    end
endmodule

`default_nettype wire

/* verification/spa_serial_port_assertions.sv */
// Checker for the serial port block, fed only from its ports.
// Assumes a bind from the bench top; one clock, synchronous reset.
`default_nettype none
module spa_checker #(
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic shadow_hold,
    input wire logic serial_data_out_oe,
    input wire logic sdio_oe,
    input wire logic buffer_ready,
    input wire logic write_dropped,
    input wire logic [DATA_W-1:0] port_config,
    input wire logic [DATA_W-1:0] feedback_a_count,
    input wire logic [DATA_W-1:0] feedback_b_count_high,
    input wire logic [DATA_W-1:0] feedback_b_count_low,
    input wire logic [DATA_W-1:0] loop_control_one
);
    // ----
    // Helpers
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [4*DATA_W-1:0] act; // Active copies as one word
    assign act = {feedback_a_count, feedback_b_count_high,
        feedback_b_count_low, loop_control_one};
    logic idle; // No frame and nothing held back in the buffer
    assign idle = chip_select_n && !shadow_hold;
    // ----
    // Assertions
    // ----
    AST_RESET_VALUES: assert property (
        $past(!rst_n) |-> port_config == 8'h10 && act == '0
        && buffer_ready && !write_dropped && !sdio_oe)
        else $error("Reset values wrong");
    AST_OE_ONE_PIN: assert property (
        !(serial_data_out_oe && sdio_oe)) else $error("Both pins driven");
    AST_OE_MODE: assert property (
        (sdio_oe |-> port_config[7]) and
        (serial_data_out_oe |-> !port_config[7]))
        else $error("Read on wrong pin");
    AST_OE_IDLE: assert property (
        chip_select_n [*4] |=> !serial_data_out_oe && !sdio_oe)
        else $error("Pin driven without select");
    AST_ACTIVE_HELD: assert property (
        idle [*8] |=> $stable(act)) else $error("Active moved when idle");
    AST_CFG_QUIET: assert property (
        idle [*8] |=> $stable(port_config)) else $error("Config moved");
    AST_DROP_FULL: assert property (
        write_dropped |-> !buffer_ready && $past(shadow_hold))
        else $error("Drop without full buffer");
    AST_DRAIN: assert property (
        !shadow_hold [*3] |-> buffer_ready) else $error("Buffer not drained");
endmodule
`default_nettype wire

/* verification/spa_host.sv */
// Host model: frames transfers, shifts bits, samples read data.
// Assumes the bench wires miso to whichever pin the device drives,
// and clk to the system clock so pin edges stay clear of its edges.
`default_nettype none
module spa_host (
    input wire logic clk,
    output logic sclk,
    output logic chip_select_n,
    output logic sdio,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic lsb_first = 1'b0; // Bit order the host has set up
    logic [7:0] got_byte; // Last byte read back
    event got; // Fires once per byte read back
    // Clock stands low and select high outside frames
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        sdio = 1'b0;
    end
    // Data moves while the clock is low, so the rise sees it settled
    task automatic shift(input logic [15:0] w, input int nb,
            output logic [15:0] r);
        int k;
        r = 16'h0000;
        for (int i = 0; i < nb; i++) begin
            k = lsb_first ? i : nb - 1 - i;
            sdio = w[k];
            #62.5 sclk = 1'b1;
            r[k] = miso;
            #62.5 sclk = 1'b0;
        end
    endtask
    // One frame: instruction, n whole bytes, then cut loose bits
    task automatic frame(input logic rw, input logic [1:0] len,
            input logic [6:0] addr, input int n, input int cut,
            input logic [31:0] wd);
        logic [15:0] r;
        // One step past a falling edge; the 62.5 steps then never
        // land on a rising edge of the system clock
        @(negedge clk);
        #1 chip_select_n = 1'b0;
        #62.5;
        shift({rw, len, 6'h00, addr}, 16, r);
        for (int i = 0; i < n; i++) begin
            shift({8'h00, wd[8*i +: 8]}, 8, r);
            got_byte = r[7:0];
            if (rw) ->got;
        end
        if (cut > 0) shift(wd[15:0], cut, r);
        #62.5 chip_select_n = 1'b1;
        sdio = ~sdio; // Released line has no pull: never the old level
        #500;
    endtask
    // Resumes a stalled write: whole bytes only, no instruction
    task automatic resume(input int n, input logic [31:0] wd);
        logic [15:0] r;
        @(negedge clk);
        #1 chip_select_n = 1'b0;
        #62.5;
        for (int i = 0; i < n; i++) shift({8'h00, wd[8*i +: 8]}, 8, r);
        #62.5 chip_select_n = 1'b1;
        sdio = ~sdio;
        #500;
    endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Top bench: clock, reset, host model, scoreboard and the tests.
// Assumes design, checker and host model are compiled before it.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic shadow_hold = 1'b0; // Stalls the buffer's drain
    logic sclk, chip_select_n, host_sdio, sdio_in, miso;
    logic serial_data_out, serial_data_out_oe, sdio_out, sdio_oe;
    logic buffer_ready, write_dropped;
    logic [7:0] port_config, fa, fbh, fbl, lc;
    logic [7:0] regs [0:7]; // Expected shadow contents
    logic [7:0] act [4:7]; // Expected active copies
    logic [7:0] exp_q [$]; // Expected read bytes, oldest first
    int failures = 0;
    int n_checks = 0;
    int drops = 0;
    always #5 sys_clk = ~sys_clk;
    // Device wins the shared pin while it drives it
    assign sdio_in = sdio_oe ? sdio_out : host_sdio;
    // A released data-out pin has no pull: show the opposite level
    assign miso = sdio_oe ? sdio_out
        : serial_data_out_oe ? serial_data_out : ~serial_data_out;
    spa_serial_port u_spa_serial_port (.sys_clk(sys_clk), .rst_n(rst_n),
        .sclk(sclk), .chip_select_n(chip_select_n), .sdio_in(sdio_in),
        .shadow_hold(shadow_hold), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .buffer_ready(buffer_ready),
        .write_dropped(write_dropped), .port_config(port_config),
        .feedback_a_count(fa), .feedback_b_count_high(fbh),
        .feedback_b_count_low(fbl), .loop_control_one(lc));
    spa_host u_spa_host (.clk(sys_clk), .sclk(sclk),
        .chip_select_n(chip_select_n),
        .sdio(host_sdio), .miso(miso));
    task automatic check8(input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tdone(input string s);
        $display("Test %s finished", s);
    endtask
    // Write, stepping the address the way the device should
    task automatic wr(input logic [6:0] a, input logic [1:0] len,
            input int n, input logic [31:0] d);
        logic [6:0] p;
        p = a;
        u_spa_host.frame(1'b0, len, a, n, 0, d);
        for (int i = 0; i < n; i++) begin
            if (p >= 4 && p <= 7) regs[p] = d[8*i +: 8];
            if (p == 0) regs[0] = {d[8*i+5 +: 3], 5'h10};
            p = u_spa_host.lsb_first ? p + 7'h01 : p - 7'h01;
        end
    endtask
    // Unmapped places read back as zero
    task automatic rd(input logic [6:0] a, input logic [1:0] len, input int n);
        logic [6:0] p;
        p = a;
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(p <= 7 ? regs[p] : 8'h00);
            p = u_spa_host.lsb_first ? p + 7'h01 : p - 7'h01;
        end
        u_spa_host.frame(1'b1, len, a, n, 0, 32'h0000_0000);
    endtask
    task automatic chk_act();
        check8(act[4], fa);
        check8(act[5], fbh);
        check8(act[6], fbl);
        check8(act[7], lc);
    endtask
    task automatic update();
        u_spa_host.frame(1'b0, 2'h0, 7'h5A, 1, 0, 32'h0000_0001);
        foreach (act[i]) act[i] = regs[i];
        chk_act();
    endtask
    // Matches each byte the host reads with the oldest note
    always @(u_spa_host.got) begin
        check8(exp_q.pop_front(), u_spa_host.got_byte);
    end
    always @(posedge sys_clk) if (write_dropped === 1'b1) drops++;
    // Cuts a hang short, well past the expected run of about 100 us
    initial begin
        #400000;
        failures++;
        stop_test();
    end
    initial begin
        logic [31:0] d;
        d = $urandom(41011); // Fixed seed, given once
        foreach (regs[i]) regs[i] = 8'h00;
        foreach (act[i]) act[i] = 8'h00;
        regs[0] = 8'h10;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        rd(7'h07, 2'h3, 8);
        tdone("reset");
        wr(7'h06, 2'h2, 3, d);
        chk_act();
        update();
        for (int l = 0; l < 4; l++) rd(7'h07, 2'(l), l + 1);
        tdone("msb");
        u_spa_host.frame(1'b0, 2'h0, 7'h07, 0, 4, ~d);
        update();
        // Two-byte write stalled on the byte boundary, then resumed
        u_spa_host.frame(1'b0, 2'h1, 7'h07, 1, 0, ~d);
        u_spa_host.resume(1, ~d >> 8);
        regs[7] = ~d[7:0];
        regs[6] = ~d[15:8];
        update();
        tdone("abort");
        wr(7'h00, 2'h0, 1, 32'h0000_0040);
        u_spa_host.lsb_first = 1'b1;
        check8(8'h50, port_config);
        d = $urandom();
        wr(7'h02, 2'h3, 4, d);
        rd(7'h01, 2'h3, 6);
        update();
        tdone("lsb");
        wr(7'h00, 2'h0, 1, 32'h0000_00C0);
        rd(7'h04, 2'h1, 2);
        tdone("bidir");
        @(negedge sys_clk) shadow_hold = 1'b1;
        d = $urandom();
        u_spa_host.frame(1'b0, 2'h3, 7'h04, 4, 0, d);
        check8(8'h02, 8'(drops));
        @(negedge sys_clk) shadow_hold = 1'b0;
        regs[4] = d[7:0];
        regs[5] = d[15:8];
        rd(7'h04, 2'h3, 4);
        tdone("full");
        stop_test();
    end
endmodule
bind spa_serial_port spa_checker #(.DATA_W(DATA_W)) u_spa_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .shadow_hold(shadow_hold), .serial_data_out_oe(serial_data_out_oe),
    .sdio_oe(sdio_oe), .buffer_ready(buffer_ready),
    .write_dropped(write_dropped), .port_config(port_config),
    .feedback_a_count(feedback_a_count),
    .feedback_b_count_high(feedback_b_count_high),
    .feedback_b_count_low(feedback_b_count_low),
    .loop_control_one(loop_control_one));
`default_nettype wire
